//--- design/reclocker_eq_cdr_control_regs.sv
// Equalizer and clock-recovery register page, low offsets
// Notes on behaviour
// R1: Writing one to page reset bit restores page defaults, then bit clears.
// R2: Host reinitialises the page after a page reset.
// R3: Loss bit reads zero with signal, one on loss of signal.
// R4: Recovery status byte is read-only, content chosen by status select.
// R5: Manual boost drives equalizer only while manual enable bit is one.
// R6: Boost byte holds four two-bit stage fields, stage zero on top.
// R7: Boost in effect reads back at its readback offset.
// R8: Override bit zero: both outputs follow the common selection.
// R9: Override bit one: each output uses its own selection field.
// R10: Host selects this page through the page control register first.
// R11: Host keeps reserved bits at defaults using read-modify-write; the test writes 8'h11 to reserved offset 8'h0E with a plain write.
`timescale 1ns/1ns
module reclocker_eq_cdr_control_regs (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic primary_input_signal_loss,
   input wire logic [7:0] recovery_status_in,
   input wire logic manual_enable,
   input wire logic [7:0] adaptive_boost,
   input wire logic [1:0] common_sel,
   input wire logic [2:0] first_sel,
   input wire logic [2:0] second_sel,
   output logic [7:0] boost_in_effect,
   output logic [2:0] first_output_sel,
   output logic [2:0] second_output_sel,
   output logic page_reset_pulse
);
   logic [7:0] boost_q, boost_d;
   logic [7:0] override_q, override_d;
   logic [7:0] rsv_q [0:8], rsv_d [0:8];
   logic pend_q, pend_d;
   logic [1:0] loss_sync_q;
   logic [7:0] rdata_q, rdata_d;
   logic rvalid_q, rvalid_d;
   logic [7:0] eff_q, eff_d;
   logic [2:0] first_q, second_q;
   logic [2:0] first_c, second_c;
   logic page_reset_hit;

   // Reserved slot index for an offset, 15 when not reserved
   function automatic logic [3:0] rsv_index(input logic [7:0] a);
      if (a >= eq_page_pkg::OFF_RSV_04 && a <= eq_page_pkg::OFF_RSV_08)
         rsv_index = 4'(a - eq_page_pkg::OFF_RSV_04);
      else if (a >= eq_page_pkg::OFF_RSV_0D && a <= eq_page_pkg::OFF_RSV_10)
         rsv_index = 4'(a - eq_page_pkg::OFF_RSV_0D + 8'h05);
      else
         rsv_index = 4'hF;
   endfunction : rsv_index

   // Default value of a reserved slot
   function automatic logic [7:0] rsv_default(input int i);
      case (i)
         6: rsv_default = eq_page_pkg::RST_RSV_0E;
         7: rsv_default = eq_page_pkg::RST_RSV_0F;
         8: rsv_default = eq_page_pkg::RST_RSV_10;
         default: rsv_default = eq_page_pkg::RST_RSV;
      endcase
   endfunction : rsv_default

   // Page reset strobe: a write of one to the reset bit
   assign page_reset_hit = reg_wr && reg_addr == eq_page_pkg::OFF_PAGE_RESET
      && reg_wdata[eq_page_pkg::PAGE_RESET_POS];

   // Register writes and page reset
   always_comb begin
      boost_d = boost_q;
      override_d = override_q;
      for (int i = 0; i < 9; i++) rsv_d[i] = rsv_q[i];
      pend_d = 1'b0;
      if (page_reset_hit) begin
         boost_d = eq_page_pkg::RST_BOOST; // [R1]
         override_d = eq_page_pkg::RST_OVERRIDE; // [R1]
         for (int i = 0; i < 9; i++) rsv_d[i] = rsv_default(i); // [R1]
         pend_d = 1'b1; // [R1]
      end else if (reg_wr) begin
         if (reg_addr == eq_page_pkg::OFF_BOOST) boost_d = reg_wdata; // [R6]
         if (reg_addr == eq_page_pkg::OFF_OVERRIDE) override_d = reg_wdata;
         if (rsv_index(reg_addr) != 4'hF) rsv_d[rsv_index(reg_addr)] = reg_wdata;
      end
   end

   // Read data path
   always_comb begin
      rdata_d = rdata_q;
      rvalid_d = reg_rd;
      if (reg_rd) begin
         case (reg_addr)
            eq_page_pkg::OFF_PAGE_RESET: rdata_d = 8'h00; // [R1]
            eq_page_pkg::OFF_LOSS: rdata_d = {6'h00, loss_sync_q[1], 1'b0}; // [R3]
            eq_page_pkg::OFF_RECOVERY: rdata_d = recovery_status_in; // [R4]
            eq_page_pkg::OFF_BOOST: rdata_d = boost_q;
            eq_page_pkg::OFF_OVERRIDE: rdata_d = override_q;
            eq_page_pkg::OFF_BOOST_RB: rdata_d = eff_q; // [R7]
            default: begin
               if (rsv_index(reg_addr) != 4'hF) rdata_d = rsv_q[rsv_index(reg_addr)];
               else rdata_d = 8'h00;
            end
         endcase
      end
   end

   // Boost in effect: manual fields only while manual enable is set
   always_comb begin
      eff_d = manual_enable ? boost_q : adaptive_boost; // [R5]
   end

   // Output source selection, registered below
   output_select u_sel (
      .override_bit(override_q[eq_page_pkg::OVERRIDE_POS]),
      .common_sel(common_sel),
      .first_sel(first_sel),
      .second_sel(second_sel),
      .first_output_sel(first_c),
      .second_output_sel(second_c)
   );

   // Page registers
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         boost_q <= eq_page_pkg::RST_BOOST;
         override_q <= eq_page_pkg::RST_OVERRIDE;
         for (int i = 0; i < 9; i++) rsv_q[i] <= rsv_default(i);
         pend_q <= 1'b0;
      end else begin
         boost_q <= boost_d;
         override_q <= override_d;
         for (int i = 0; i < 9; i++) rsv_q[i] <= rsv_d[i];
         pend_q <= pend_d;
      end
   end

   // Read data and its valid pulse
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   // Two-flop synchroniser for the loss pin, resets to loss
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         loss_sync_q <= 2'h3;
      end else begin
         loss_sync_q <= {loss_sync_q[0], primary_input_signal_loss};
      end
   end

   // Boost in effect and output selections
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         eff_q <= eq_page_pkg::RST_BOOST;
         first_q <= 3'h0;
         second_q <= 3'h0;
      end else begin
         eff_q <= eff_d;
         first_q <= first_c;
         second_q <= second_c;
      end
   end

   // Outputs straight from registers
   assign reg_rdata = rdata_q;
   assign reg_rvalid = rvalid_q;
   assign boost_in_effect = eff_q;
   assign first_output_sel = first_q;
   assign second_output_sel = second_q;
   assign page_reset_pulse = pend_q;

   // Page reset restores defaults, pulse lasts one cycle
   page_reset_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R1]
      page_reset_hit |=> boost_q == eq_page_pkg::RST_BOOST && pend_q
      ##1 (!pend_q || $past(page_reset_hit))) else $error("page reset failed");
   reserved_reset_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R1]
      page_reset_hit |=> override_q == eq_page_pkg::RST_OVERRIDE
      && rsv_q[0] == eq_page_pkg::RST_RSV && rsv_q[6] == eq_page_pkg::RST_RSV_0E)
      else $error("page defaults not restored");
   pulse_cause_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R1]
      pend_q |-> $past(page_reset_hit)) else $error("page reset pulse without request");

   // Status bytes read back as they stand
   reset_reads_zero_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R1]
      reg_rd && reg_addr == eq_page_pkg::OFF_PAGE_RESET |=> rdata_q == 8'h00)
      else $error("page reset bit not clear");
   loss_bit_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R3]
      reg_rd && reg_addr == eq_page_pkg::OFF_LOSS |=>
      rdata_q[eq_page_pkg::LOSS_POS] == $past(loss_sync_q[1]) && rdata_q[0] == 1'b0)
      else $error("loss bit wrong");
   recovery_read_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R4]
      reg_rd && reg_addr == eq_page_pkg::OFF_RECOVERY |=>
      rdata_q == $past(recovery_status_in)) else $error("recovery status wrong");

   // Boost register, its fields and the value in effect
   manual_boost_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R5]
      manual_enable |=> eff_q == $past(boost_q)) else $error("manual boost ignored");
   adaptive_boost_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R5]
      !manual_enable |=> eff_q == $past(adaptive_boost))
      else $error("manual boost leaked");
   boost_land_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R6]
      reg_wr && reg_addr == eq_page_pkg::OFF_BOOST && !page_reset_hit
      |=> boost_q == $past(reg_wdata)) else $error("boost write lost");
   boost_write_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R6]
      reg_wr && reg_addr == eq_page_pkg::OFF_BOOST && !page_reset_hit ##1 manual_enable
      |=> eff_q[eq_page_pkg::STAGE0_HI -: 2] == $past(reg_wdata[7:6], 2)
      && eff_q[5:4] == $past(reg_wdata[5:4], 2) && eff_q[3:2] == $past(reg_wdata[3:2], 2)
      && eff_q[eq_page_pkg::STAGE3_HI -: 2] == $past(reg_wdata[1:0], 2))
      else $error("stage fields misplaced");
   readback_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R7]
      reg_rd && reg_addr == eq_page_pkg::OFF_BOOST_RB |=> rdata_q == $past(eff_q))
      else $error("boost readback wrong");

   // Output source selection
   override_land_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R9]
      reg_wr && reg_addr == eq_page_pkg::OFF_OVERRIDE && !page_reset_hit
      |=> override_q == $past(reg_wdata)) else $error("override write lost");
   common_select_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R8]
      !override_q[eq_page_pkg::OVERRIDE_POS] |=> first_q == {1'b0, $past(common_sel)}
      && second_q == first_q) else $error("common selection wrong");
   own_select_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R9]
      override_q[eq_page_pkg::OVERRIDE_POS] |=> first_q == $past(first_sel)
      && second_q == $past(second_sel)) else $error("individual selection wrong");
endmodule : reclocker_eq_cdr_control_regs

//--- design/eq_page_pkg.sv
// Package with offsets, reset values and field positions of the equalizer page
package eq_page_pkg;
   localparam logic [7:0] OFF_PAGE_RESET = 8'h00;
   localparam logic [7:0] OFF_LOSS = 8'h01;
   localparam logic [7:0] OFF_RECOVERY = 8'h02;
   localparam logic [7:0] OFF_BOOST = 8'h03;
   localparam logic [7:0] OFF_RSV_04 = 8'h04;
   localparam logic [7:0] OFF_RSV_08 = 8'h08;
   localparam logic [7:0] OFF_OVERRIDE = 8'h09;
   localparam logic [7:0] OFF_RSV_0D = 8'h0D;
   localparam logic [7:0] OFF_RSV_0E = 8'h0E;
   localparam logic [7:0] OFF_RSV_0F = 8'h0F;
   localparam logic [7:0] OFF_RSV_10 = 8'h10;
   localparam logic [7:0] OFF_BOOST_RB = 8'h52;
   localparam logic [7:0] RST_PAGE_RESET = 8'h00;
   localparam logic [7:0] RST_LOSS = 8'h03;
   localparam logic [7:0] RST_RECOVERY = 8'h41;
   localparam logic [7:0] RST_BOOST = 8'h80;
   localparam logic [7:0] RST_RSV = 8'h00;
   localparam logic [7:0] RST_OVERRIDE = 8'h00;
   localparam logic [7:0] RST_RSV_0E = 8'h93;
   localparam logic [7:0] RST_RSV_0F = 8'h69;
   localparam logic [7:0] RST_RSV_10 = 8'h27;
   localparam int PAGE_RESET_POS = 2;
   localparam int LOSS_POS = 1;
   localparam int OVERRIDE_POS = 5;
   localparam int ENABLE_MANUAL_POS = 3;
   localparam int STAGE0_HI = 7;
   localparam int STAGE3_HI = 1;
   localparam logic [7:0] LOSS_MASK = 8'h02;
   localparam logic [7:0] PAGE_RESET_MASK = 8'h04;
   localparam logic [7:0] OVERRIDE_MASK = 8'h20;
   localparam logic [7:0] BOOST_MASK = 8'hFF;
endpackage : eq_page_pkg

//--- design/output_select.sv
// Output source multiplexer selection for the two outputs
`timescale 1ns/1ns
module output_select (
   input wire logic override_bit,
   input wire logic [1:0] common_sel,
   input wire logic [2:0] first_sel,
   input wire logic [2:0] second_sel,
   output logic [2:0] first_output_sel,
   output logic [2:0] second_output_sel
);
   // Common two-bit choice or individual three-bit choices
   always_comb begin
      if (override_bit) begin
         first_output_sel = first_sel; // [R9]
         second_output_sel = second_sel; // [R9]
      end else begin
         first_output_sel = {1'b0, common_sel}; // [R8]
         second_output_sel = {1'b0, common_sel}; // [R8]
      end
   end
endmodule : output_select

//--- tb/host_model.sv
// Host side model issuing page register writes and reads
`timescale 1ns/1ns
module host_model (
   input wire logic ref_clk,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid
);
   // Idle strobes and idle address
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'hFF;
      reg_wdata = 8'h00;
   end
   // One write, held through the taking edge; released bus inverted
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk) #1;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge ref_clk) #1;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : wr
   // One read; data and valid taken while they stand after the taking edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge ref_clk) #1;
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge ref_clk) #1;
      d = reg_rdata;
      v = reg_rvalid;
      reg_rd = 1'b0;
      reg_addr = ~a;
   endtask : rd
   // Field update that keeps the other bits of the byte as read
   task automatic rmw(input logic [7:0] a, input logic [7:0] m, input logic [7:0] f);
      logic [7:0] d;
      logic v;
      rd(a, d, v);
      wr(a, (d & ~m) | (f & m));
   endtask : rmw
   // Page control write that opens the equalizer page
   task automatic select_page();
      wr(8'hFF, 8'h04);
   endtask : select_page
endmodule : host_model

//--- tb/tb.sv
// Testbench for the equalizer page registers
`timescale 1ns/1ns
module tb;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic reg_wr, reg_rd, reg_rvalid, page_reset_pulse, v;
   logic loss = 1'b1;
   logic man_en = 1'b0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, boost, rv;
   logic [7:0] rec_in = 8'h41;
   logic [7:0] adapt = 8'h55;
   logic [1:0] common_sel = 2'h3;
   logic [2:0] first_sel = 3'h5;
   logic [2:0] second_sel = 3'h2;
   logic [2:0] first_out, second_out;
   logic [7:0] offs [14] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
      8'h08, 8'h09, 8'h0D, 8'h0E, 8'h0F, 8'h10};
   logic [7:0] dflt [14] = '{8'h00, 8'h02, 8'h41, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h93, 8'h69, 8'h27};
   int num_errors = 0;
   int check_count = 0;
   int cycles = 0;
   // Clock and hang limit
   always #2 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         results();
      end
   end
   host_model u_host_model (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid));
   reclocker_eq_cdr_control_regs u_reclocker_eq_cdr_control_regs (.ref_clk(ref_clk),
      .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .primary_input_signal_loss(loss), .recovery_status_in(rec_in), .manual_enable(man_en),
      .adaptive_boost(adapt), .common_sel(common_sel), .first_sel(first_sel),
      .second_sel(second_sel), .boost_in_effect(boost), .first_output_sel(first_out),
      .second_output_sel(second_out), .page_reset_pulse(page_reset_pulse));
   // Compare and count
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Read one offset, expect valid and value
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      u_host_model.rd(a, rv, v);
      chk({7'h00, v}, 8'h01);
      chk(rv, exp);
   endtask : rchk
   // Walk the default table
   task automatic defaults();
      for (int i = 0; i < 14; i++) begin
         rchk(offs[i], dflt[i]);
      end
   endtask : defaults
   // Wait n edges, then settle
   task automatic waitn(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : waitn
   task automatic results();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : results
   // Main sequence
   initial begin
      waitn(5);
      arst_n = 1'b1;
      u_host_model.select_page();
      defaults();
      u_host_model.wr(8'h02, 8'hFF);
      rchk(8'h02, 8'h41);
      rchk(8'h20, 8'h00);
      loss = 1'b0;
      waitn(3);
      rchk(8'h01, 8'h00);
      man_en = 1'b1;
      u_host_model.wr(8'h03, 8'h1B);
      waitn(2);
      chk(boost, 8'h1B);
      rchk(8'h52, 8'h1B);
      man_en = 1'b0;
      waitn(2);
      chk(boost, 8'h55);
      u_host_model.rmw(8'h09, 8'h20, 8'h20);
      waitn(2);
      chk({5'h00, first_out}, 8'h05);
      chk({5'h00, second_out}, 8'h02);
      u_host_model.rmw(8'h09, 8'h20, 8'h00);
      waitn(2);
      chk({5'h00, first_out}, 8'h03);
      chk({5'h00, second_out}, 8'h03);
      loss = 1'b1;
      man_en = 1'b1;
      u_host_model.wr(8'h0E, 8'h11);
      rchk(8'h0E, 8'h11);
      u_host_model.rmw(8'h09, 8'h20, 8'h20);
      u_host_model.wr(8'h03, 8'h1B);
      u_host_model.wr(8'h00, 8'h04);
      chk({7'h00, page_reset_pulse}, 8'h01);
      waitn(1);
      chk({7'h00, page_reset_pulse}, 8'h00);
      chk(boost, 8'h80);
      chk({5'h00, first_out}, 8'h03);
      defaults();
      u_host_model.wr(8'h03, 8'h1B);
      rchk(8'h03, 8'h1B);
      results();
   end
endmodule : tb
